//--- inc/etpc_pkg.sv
// package: constants and types for the ethertype protocol classifier
package etpc_pkg;
  localparam int unsigned PREAMBLE_OCTETS = 7;
  localparam int unsigned SFD_OCTETS      = 1;
  localparam logic [7:0]  SFD_VALUE       = 8'hd5;
  localparam int unsigned DST_OFFSET      = 0;
  localparam int unsigned SRC_OFFSET      = 6;
  localparam int unsigned TYPE_OFFSET     = 12;
  localparam int unsigned VLAN_OCTETS     = 4;
  localparam int unsigned MAC_OCTETS      = 6;
  localparam logic [15:0] TYPE_VLAN       = 16'h8100;
  localparam logic [15:0] TYPE_CLASS_A    = 16'h88ae;
  localparam logic [15:0] TYPE_CLASS_B    = 16'h8892;
  localparam logic [15:0] TYPE_CLASS_C    = 16'h88cd;
  localparam logic [15:0] TYPE_CLASS_D    = 16'h88ab;
  localparam logic [15:0] TYPE_IP         = 16'h8000;
  localparam logic [47:0] VENDOR_LO_RESET = 48'h0000_0000_0000;
  localparam logic [47:0] VENDOR_HI_RESET = 48'h0000_00ff_ffff;
  localparam logic [9:0]  BUF_DEPTH_RESET = 10'h020;

  typedef enum logic [2:0] {
    CLASS_NONE = 3'h0,
    CLASS_A    = 3'h1,
    CLASS_B    = 3'h2,
    CLASS_C    = 3'h3,
    CLASS_D    = 3'h4,
    CLASS_E    = 3'h5
  } etpc_class_type;

  // gray along link -> hunt -> store -> type -> classify path
  typedef enum logic [2:0] {
    ST_LINK     = 3'b000,
    ST_HUNT     = 3'b001,
    ST_STORE    = 3'b011,
    ST_TYPE     = 3'b010,
    ST_CLASSIFY = 3'b110,
    ST_DONE     = 3'b111
  } etpc_state_type;
endpackage

//--- hw/etpc_classifier.sv
// module: mii receive, frame store and ethertype classification
`timescale 1ns/1ns
// Functional notes
// - preamble and delimiter octets never stored
// - destination then source address stored first
// - untagged type field read at offset twelve
// - classify only after frame end, first BUF_DEPTH octets stored
// - map 88ae, 8892, 88cd to classes A-C
// - 88ab is class D, 8000 candidate E
// - IP needs source in vendor range
// - wait for PHY link before accepting frames
// - request system reset after class found
// - raise event, keep classifying, update class
module etpc_classifier #(
  parameter int unsigned BUF_DEPTH = 32,
  parameter logic [47:0] VENDOR_LO = etpc_pkg::VENDOR_LO_RESET,
  parameter logic [47:0] VENDOR_HI = etpc_pkg::VENDOR_HI_RESET
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // mii receive pins
  input  wire logic                      rx_clk,
  input  wire logic                      rx_dv,
  input  wire logic [3:0]                rxd,
  input  wire logic                      link_up,
  // host side
  output logic      [2:0]                detected_class,
  output logic                           detect_event,
  output logic                           reset_request
);
  localparam int unsigned AW = $clog2(BUF_DEPTH);

  typedef struct packed {
    logic [2:0]           rclk_s;
    logic [1:0]           dv_s1;
    logic                 dv_last;
    logic [3:0]           d_s1;
    logic [3:0]           d_s2;
    logic [1:0]           lk_s;
    logic [3:0]           lo_nib;
    logic                 half;
    logic [3:0]           pre_cnt;
    logic [10:0]          cnt;
    logic [BUF_DEPTH*8-1:0] mem;
    etpc_pkg::etpc_state_type st;
    logic [15:0]          etype;
    logic [2:0]           cls;
    logic                 evt;
    logic                 rst_req;
  } etpc_state_struct_type;

  etpc_state_struct_type r;
  etpc_state_struct_type next_r;

  // byte read from frame memory by index
  function automatic logic [7:0] rd_byte(input logic [BUF_DEPTH*8-1:0] m,
                                         input int unsigned idx);
    rd_byte = m[idx*8 +: 8];
  endfunction

  function automatic logic [47:0] rd_mac(input logic [BUF_DEPTH*8-1:0] m,
                                         input int unsigned base);
    logic [47:0] v;
    v = '0;
    for (int i = 0; i < 6; i++) begin
      v[47-8*i -: 8] = rd_byte(m, base + i);
    end
    rd_mac = v;
  endfunction

  always_comb begin
    logic       rise;
    logic [7:0] byte_v;
    logic [47:0] src;
    next_r = r;
    rise   = 1'b0;
    byte_v = '0;
    src    = '0;
    // two flops on every pin before use
    next_r.rclk_s = {r.rclk_s[1:0], rx_clk};
    next_r.dv_s1  = {r.dv_s1[0], rx_dv};
    next_r.d_s1   = rxd;
    next_r.d_s2   = r.d_s1;
    next_r.lk_s   = {r.lk_s[0], link_up};
    next_r.evt    = 1'b0;
    next_r.rst_req = 1'b0;
    rise = r.rclk_s[1] & ~r.rclk_s[2];
    // valid level at the last rx_clk rise; a frame already running at link-up is not entered
    next_r.dv_last = rise ? r.dv_s1[1] : r.dv_last;
    byte_v = {r.d_s2, r.lo_nib};
    case (r.st)
      etpc_pkg::ST_LINK: begin
        if (r.lk_s[1]) begin
          next_r.st = etpc_pkg::ST_HUNT;
        end
      end
      etpc_pkg::ST_HUNT: begin
        next_r.half    = 1'b0;
        next_r.cnt     = '0;
        if (!r.lk_s[1]) begin
          next_r.st = etpc_pkg::ST_LINK;
        end else if (rise && r.dv_s1[1] && !r.dv_last) begin
          // frame opens; preamble octets are skipped, not stored
          next_r.pre_cnt = '0;
          next_r.st      = etpc_pkg::ST_STORE;
          next_r.lo_nib  = r.d_s2;
          next_r.half    = 1'b1;
        end
      end
      etpc_pkg::ST_STORE: begin
        if (rise) begin
          if (!r.dv_s1[1]) begin
            next_r.st = etpc_pkg::ST_TYPE;
          end else if (!r.half) begin
            next_r.lo_nib = r.d_s2;
            next_r.half   = 1'b1;
          end else begin
            next_r.half = 1'b0;
            if (r.pre_cnt != 4'(etpc_pkg::PREAMBLE_OCTETS + etpc_pkg::SFD_OCTETS)) begin
              // discard preamble until delimiter seen
              if (byte_v == etpc_pkg::SFD_VALUE) begin
                next_r.pre_cnt = 4'(etpc_pkg::PREAMBLE_OCTETS + etpc_pkg::SFD_OCTETS);
              end
            end else begin
              // destination lands at index 0, source at 6
              if (r.cnt < 11'(BUF_DEPTH)) begin
                next_r.mem[r.cnt[AW-1:0]*8 +: 8] = byte_v;
              end
              // long frames only keep the head; the tail is not needed
              if (r.cnt != 11'h7ff) begin
                next_r.cnt = r.cnt + 11'h001;
              end
            end
          end
        end
      end
      etpc_pkg::ST_TYPE: begin
        // read type field back from frame memory
        next_r.etype = {rd_byte(r.mem, etpc_pkg::TYPE_OFFSET),
                        rd_byte(r.mem, etpc_pkg::TYPE_OFFSET + 1)};
        if (next_r.etype == etpc_pkg::TYPE_VLAN) begin
          next_r.etype = {rd_byte(r.mem, etpc_pkg::TYPE_OFFSET + etpc_pkg::VLAN_OCTETS),
                          rd_byte(r.mem, etpc_pkg::TYPE_OFFSET + etpc_pkg::VLAN_OCTETS + 1)};
          // a short tagged frame would otherwise read stale bytes of an older frame
          if (r.cnt < 11'(etpc_pkg::TYPE_OFFSET + etpc_pkg::VLAN_OCTETS + 2)) begin
            next_r.etype = '0;
          end
        end
        // runt frames never reach the type field
        if (r.cnt < 11'(etpc_pkg::TYPE_OFFSET + 2)) begin
          next_r.etype = '0;
        end
        next_r.st = etpc_pkg::ST_CLASSIFY;
      end
      etpc_pkg::ST_CLASSIFY: begin
        src = rd_mac(r.mem, etpc_pkg::SRC_OFFSET);
        next_r.st = etpc_pkg::ST_DONE;
        case (r.etype)
          etpc_pkg::TYPE_CLASS_A: next_r.cls = etpc_pkg::CLASS_A;
          etpc_pkg::TYPE_CLASS_B: next_r.cls = etpc_pkg::CLASS_B;
          etpc_pkg::TYPE_CLASS_C: next_r.cls = etpc_pkg::CLASS_C;
          etpc_pkg::TYPE_CLASS_D: next_r.cls = etpc_pkg::CLASS_D;
          etpc_pkg::TYPE_IP: begin
            if (src >= VENDOR_LO && src <= VENDOR_HI) begin
              next_r.cls = etpc_pkg::CLASS_E;
            end else begin
              next_r.st = etpc_pkg::ST_HUNT;
            end
          end
          default: next_r.st = etpc_pkg::ST_HUNT;
        endcase
      end
      etpc_pkg::ST_DONE: begin
        next_r.evt     = 1'b1;
        next_r.rst_req = 1'b1;
        next_r.st      = etpc_pkg::ST_HUNT;
      end
      default: next_r.st = etpc_pkg::ST_LINK;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r     <= '0;
      r.st  <= etpc_pkg::ST_LINK;
      r.cls <= etpc_pkg::CLASS_NONE;
    end else begin
      r <= next_r;
    end
  end

  assign detected_class = r.cls;
  assign detect_event   = r.evt;
  assign reset_request  = r.rst_req;
endmodule

//--- verification/etpc_classifier_properties.sv
// checker: port properties of the classifier
`timescale 1ns/1ns
module etpc_classifier_chk (
  // clock, reset and inputs
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       rx_dv,
  input wire logic       link_up,
  // host side
  input wire logic [2:0] detected_class,
  input wire logic       detect_event,
  input wire logic       reset_request
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_pulse;
    detect_event && reset_request ##1 !detect_event && !reset_request;
  endsequence
  sequence s_no_link;
    !link_up [*8];
  endsequence
  chk_pulse_pair: assert property (reset_request |-> detect_event)
    else $error("reset request alone");
  chk_pulse_once: assert property (detect_event |-> s_pulse)
    else $error("bad event pulse");
  chk_class_valid: assert property (detect_event |->
    detected_class inside {[3'h1:3'h5]} && $stable(detected_class)) else $error("bad class");
  chk_class_cause: assert property ($changed(detected_class) |=> detect_event)
    else $error("class moved without event");
  chk_link_gate: assert property (s_no_link |-> !detect_event)
    else $error("event without link");
  chk_frame_whole: assert property (rx_dv [*8] |-> !detect_event)
    else $error("event inside frame");
  chk_end_first: assert property (detect_event |-> $past(rx_dv, 4) == 1'b0)
    else $error("event before frame end");
  chk_reset_clear: assert property ($rose(rstn) |-> detected_class == 3'h0
    && !detect_event && !reset_request) else $error("outputs not cleared");
endmodule
bind etpc_classifier etpc_classifier_chk etpc_classifier_chk_i (.core_clk(core_clk),
  .rstn(rstn), .rx_dv(rx_dv), .link_up(link_up), .detected_class(detected_class),
  .detect_event(detect_event), .reset_request(reset_request));

//--- verification/etpc_phy_model.sv
// model: phy receive side, one frame per call
`timescale 1ns/1ns
module etpc_phy_model (
  // mii receive pins
  output logic       rx_clk,
  output logic       rx_dv,
  output logic [3:0] rxd
);
  logic [7:0] b [$];
  initial begin
    rx_clk = 1'b0;
    rx_dv  = 1'b0;
    rxd    = 4'h0;
  end
  task automatic nib(input logic dv, input logic [3:0] n);
    rx_dv = dv;
    rxd   = n;
    #160 rx_clk = 1'b1;
    #160 rx_clk = 1'b0;
  endtask
  // clock stands still between frames, so rxd is flipped to avoid a stale match
  task automatic frame(input logic [47:0] src, input logic [15:0] ty, input logic tag);
    b = {};
    for (int i = 0; i < 7; i++) b.push_back(8'h55);
    b.push_back(8'hd5);
    for (int i = 0; i < 6; i++) b.push_back(8'h02);
    for (int i = 5; i >= 0; i--) b.push_back(src[8*i +: 8]);
    if (tag) b = {b, 8'h81, 8'h00, 8'h00, 8'h07};
    b = {b, ty[15:8], ty[7:0], 8'h3c, 8'ha5};
    foreach (b[i]) begin
      nib(1'b1, b[i][3:0]);
      nib(1'b1, b[i][7:4]);
    end
    nib(1'b0, ~rxd);
    rxd = ~rxd;
  endtask
endmodule

//--- verification/etpc_classifier_tb.sv
// testbench: every class, rejects, tagged frames, link and reset
`timescale 1ns/1ns
module etpc_classifier_tb;
  logic       core_clk;
  logic       rstn;
  logic       link_up;
  logic       rx_clk;
  logic       rx_dv;
  logic [3:0] rxd;
  logic [2:0] detected_class;
  logic       detect_event;
  logic       reset_request;
  int         errors;
  int         n_compared;
  int         n_ev;
  int         n_rr;
  localparam logic [47:0] SRC_OUT = 48'h0000_0100_0000;
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  etpc_phy_model etpc_phy_model_i (.rx_clk(rx_clk), .rx_dv(rx_dv), .rxd(rxd));
  etpc_classifier etpc_classifier_i (.core_clk(core_clk), .rstn(rstn), .rx_clk(rx_clk),
    .rx_dv(rx_dv), .rxd(rxd), .link_up(link_up), .detected_class(detected_class),
    .detect_event(detect_event), .reset_request(reset_request));
  // counted on the falling edge, where the pulses are settled
  always @(negedge core_clk) begin
    if (detect_event === 1'b1) n_ev++;
    if (reset_request === 1'b1) n_rr++;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // settle span lies well past the three-cycle answer
  task automatic send(input logic [47:0] src, input logic [15:0] ty, input logic tag,
                      input int ev, input logic [2:0] cls);
    n_ev = 0;
    n_rr = 0;
    etpc_phy_model_i.frame(src, ty, tag);
    repeat (30) @(negedge core_clk);
    check("events", 8'(ev), 8'(n_ev));
    check("resets", 8'(ev), 8'(n_rr));
    check("class", {5'h0, cls}, {5'h0, detected_class});
  endtask
  task automatic t_classes();
    logic [15:0] ty [5];
    ty = '{etpc_pkg::TYPE_CLASS_A, etpc_pkg::TYPE_CLASS_B, etpc_pkg::TYPE_CLASS_C,
           etpc_pkg::TYPE_CLASS_D, etpc_pkg::TYPE_IP};
    for (int i = 0; i < 5; i++) send(etpc_pkg::VENDOR_HI_RESET, ty[i], 1'b0, 1, 3'(i + 1));
  endtask
  task automatic t_reject();
    send(etpc_pkg::VENDOR_HI_RESET, 16'h0800, 1'b0, 0, 3'h5);
    send(SRC_OUT, etpc_pkg::TYPE_IP, 1'b0, 0, 3'h5);
  endtask
  task automatic t_vlan();
    send(SRC_OUT, etpc_pkg::TYPE_CLASS_C, 1'b1, 1, 3'h3);
    send(SRC_OUT, etpc_pkg::TYPE_CLASS_C, 1'b1, 1, 3'h3);
  endtask
  task automatic t_reset();
    rstn = 1'b0;
    repeat (4) @(negedge core_clk);
    check("class", 8'h00, {5'h0, detected_class});
    rstn = 1'b1;
    // link must be seen again before a frame is taken
    repeat (4) @(negedge core_clk);
    send(SRC_OUT, etpc_pkg::TYPE_CLASS_D, 1'b0, 1, 3'h4);
  endtask
  initial begin
    rstn = 1'b0;
    link_up = 1'b0;
    errors = 0;
    n_compared = 0;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    send(etpc_pkg::VENDOR_HI_RESET, etpc_pkg::TYPE_CLASS_A, 1'b0, 0, 3'h0);
    link_up = 1'b1;
    repeat (4) @(negedge core_clk);
    t_classes();
    t_reject();
    t_vlan();
    t_reset();
    wrap_up();
  end
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
endmodule
